/* File: dadc_defines.svh */
// Purpose: Constants for the dual converter output control block
// Assumes: Included by bare name
// Notes: Offsets are byte addresses of 32-bit words
`ifndef DADC_DEFINES_SVH
`define DADC_DEFINES_SVH
`define DADC_OFS_CTRL 6'h00
`define DADC_OFS_STAT 6'h04
`define DADC_OFS_IRQ_STAT 6'h08
`define DADC_OFS_IRQ_EN 6'h0C
`define DADC_OFS_IRQ_CLR 6'h10
`define DADC_OFS_RES_A 6'h14
`define DADC_OFS_RES_B 6'h18
`define DADC_CTRL_RST 32'h0000_0000
`define DADC_CTRL_STEER 0
`define DADC_CTRL_MODE_LO 1
`define DADC_CTRL_MODE_HI 2
`define DADC_CTRL_PD_A 3
`define DADC_CTRL_PD_B 4
`define DADC_CTRL_OEN_A 5
`define DADC_CTRL_OEN_B 6
`define DADC_CTRL_MASK 32'h0000_007F
`define DADC_IRQ_RANGE 0
`define DADC_IRQ_RDY_A 1
`define DADC_IRQ_RDY_B 2
`define DADC_IRQ_MASK 3'h7
`define DADC_LATENCY 5
`define DADC_LAT_W 3
`define DADC_RES_W 14
`define DADC_MODE_W 2
`endif

/* File: dadc_pkg.sv */
// Purpose: Types for the dual converter output control block
// Assumes: dadc_defines.svh holds the widths and offsets; the enum codes are set here
// Notes: Mode codes follow the four select levels
package dadc_pkg;
  `include "dadc_defines.svh"
  typedef logic [`DADC_RES_W-1:0] dadc_word_t;
  typedef enum logic [3:0] {
    DADC_RUN_DRIVE = 4'h1,
    DADC_RUN_HIZ = 4'h2,
    DADC_NAP = 4'h4,
    DADC_SLEEP = 4'h8
  } dadc_power_e;
  typedef enum logic [1:0] {
    DADC_SEL_GND = 2'h0,
    DADC_SEL_THIRD = 2'h1,
    DADC_SEL_TWO_THIRDS = 2'h2,
    DADC_SEL_FULL = 2'h3
  } dadc_mode_e;
endpackage

/* File: dadc_output_control.sv */
// Purpose: Output side of a dual 14-bit converter with AXI4-Lite control
// Assumes: Sample clocks arrive asynchronously and are slower than i_clk / 4
// Notes: Raw codes enter as offset binary with range flags, one per sample clock
`timescale 1ns/100ps
`default_nettype none
`include "dadc_defines.svh"
module dadc_output_control
  import dadc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sample_clock_chan_a,
  input wire logic i_sample_clock_chan_b,
  input wire logic [13:0] i_raw_a,
  input wire logic [13:0] i_raw_b,
  input wire logic i_range_a,
  input wire logic i_range_b,
  input wire logic [5:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [5:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [13:0] o_result_bus_a,
  output logic [13:0] o_result_bus_b,
  output logic o_result_bus_a_oe_n,
  output logic o_result_bus_b_oe_n,
  output logic o_data_ready_clock,
  output logic o_range_exceeded_flag,
  output logic o_stabilizer_on,
  output logic [3:0] o_power_state_a,
  output logic [3:0] o_power_state_b,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic last_a;
    logic last_b;
    logic [`DADC_LATENCY*`DADC_RES_W-1:0] pipe_a;
    logic [`DADC_LATENCY*`DADC_RES_W-1:0] pipe_b;
    logic [`DADC_LATENCY-1:0] rng_a;
    logic [`DADC_LATENCY-1:0] rng_b;
    dadc_word_t res_a;
    dadc_word_t res_b;
    logic ovr_a;
    logic ovr_b;
    logic [13:0] bus_a;
    logic [13:0] bus_b;
    logic oe_n_a;
    logic oe_n_b;
    logic dr_clk;
    logic range_flag;
    logic [6:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic aw_got;
    logic w_got;
    logic [5:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dadc_state_s;

  dadc_state_s st;
  dadc_state_s next_st;
  dadc_power_e pwr_a;
  dadc_power_e pwr_b;
  dadc_mode_e mode_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Power state decode per channel from the two control bits

  function automatic dadc_power_e dadc_power(input logic pd, input logic oe_n);
    dadc_power_e p;
    p = DADC_RUN_DRIVE;
    unique case ({pd, oe_n})
      2'b00: p = DADC_RUN_DRIVE;
      2'b01: p = DADC_RUN_HIZ;
      2'b10: p = DADC_NAP;
      2'b11: p = DADC_SLEEP;
    endcase
    return p;
  endfunction

  // Two's complement is the offset word with its top bit flipped
  function automatic dadc_word_t dadc_format(input dadc_word_t w, input logic twos);
    dadc_word_t f;
    f = w;
    f[`DADC_RES_W-1] = w[`DADC_RES_W-1] ^ twos;
    return f;
  endfunction

  assign pwr_a = dadc_power(st.ctrl[`DADC_CTRL_PD_A], st.ctrl[`DADC_CTRL_OEN_A]);
  assign pwr_b = dadc_power(st.ctrl[`DADC_CTRL_PD_B], st.ctrl[`DADC_CTRL_OEN_B]);
  assign mode_sel = dadc_mode_e'(st.ctrl[`DADC_CTRL_MODE_HI:`DADC_CTRL_MODE_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic rise_a;
    logic rise_b;
    logic twos;
    logic run_a;
    logic run_b;
    logic wr_fire;
    logic [2:0] ev;
    logic [31:0] wmask;
    rise_a = 1'b0;
    rise_b = 1'b0;
    twos = 1'b0;
    run_a = 1'b0;
    run_b = 1'b0;
    wr_fire = 1'b0;
    ev = 3'h0;
    wmask = 32'h0000_0000;
    next_st = st;
    // Two flops before edge detection; only the second flop feeds logic
    next_st.sync_a = {st.sync_a[0], i_sample_clock_chan_a};
    next_st.sync_b = {st.sync_b[0], i_sample_clock_chan_b};
    next_st.last_a = st.sync_a[1];
    next_st.last_b = st.sync_b[1];
    rise_a = st.sync_a[1] & ~st.last_a;
    rise_b = st.sync_b[1] & ~st.last_b;
    twos = (mode_sel == DADC_SEL_TWO_THIRDS) || (mode_sel == DADC_SEL_FULL);
    // Nap and sleep halt the pipeline; the Hi-Z run state keeps converting
    run_a = (pwr_a == DADC_RUN_DRIVE) || (pwr_a == DADC_RUN_HIZ);
    run_b = (pwr_b == DADC_RUN_DRIVE) || (pwr_b == DADC_RUN_HIZ);
    if (rise_a && run_a) begin
      // Five-stage shift: result leaves on the fifth edge after capture
      next_st.pipe_a = {st.pipe_a[(`DADC_LATENCY-1)*`DADC_RES_W-1:0], i_raw_a};
      next_st.rng_a = {st.rng_a[`DADC_LATENCY-2:0], i_range_a};
      next_st.res_a = dadc_format(st.pipe_a[`DADC_LATENCY*`DADC_RES_W-1 -: `DADC_RES_W], twos);
      next_st.ovr_a = st.rng_a[`DADC_LATENCY-1];
      ev[`DADC_IRQ_RDY_A] = 1'b1;
    end
    if (rise_b && run_b) begin
      next_st.pipe_b = {st.pipe_b[(`DADC_LATENCY-1)*`DADC_RES_W-1:0], i_raw_b};
      next_st.rng_b = {st.rng_b[`DADC_LATENCY-2:0], i_range_b};
      next_st.res_b = dadc_format(st.pipe_b[`DADC_LATENCY*`DADC_RES_W-1 -: `DADC_RES_W], twos);
      next_st.ovr_b = st.rng_b[`DADC_LATENCY-1];
      ev[`DADC_IRQ_RDY_B] = 1'b1;
    end
    // Bus steering, bit 13 is the MSB on both buses
    if (st.ctrl[`DADC_CTRL_STEER]) begin
      next_st.bus_a = st.res_a;
      next_st.bus_b = st.res_b;
      next_st.oe_n_a = (pwr_a != DADC_RUN_DRIVE);
      next_st.oe_n_b = (pwr_b != DADC_RUN_DRIVE);
    end else begin
      next_st.bus_a = st.res_b;
      next_st.bus_b = st.res_a;
      next_st.oe_n_a = (pwr_b != DADC_RUN_DRIVE);
      next_st.oe_n_b = (pwr_a != DADC_RUN_DRIVE);
    end
    // Data-ready follows channel B clock so its fall lands mid-word
    next_st.dr_clk = st.sync_b[1];
    next_st.range_flag = st.ovr_a | st.ovr_b;
    ev[`DADC_IRQ_RANGE] = (st.ovr_a | st.ovr_b) & ~st.range_flag;
    // Write channel: address and data taken in either order
    if (i_awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    wr_fire = st.aw_got && st.w_got && !st.bvalid;
    if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        wmask[i*8 +: 8] = {8{st.wstrb[i]}};
      end
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'h0;
      unique case ({st.awaddr[5:2], 2'h0})
        `DADC_OFS_CTRL: begin
          next_st.ctrl = 7'((st.wdata & wmask & `DADC_CTRL_MASK) | (32'(st.ctrl) & ~wmask));
        end
        `DADC_OFS_IRQ_EN: begin
          if (st.wstrb[0]) begin
            next_st.irq_en = st.wdata[2:0] & `DADC_IRQ_MASK;
          end
        end
        `DADC_OFS_IRQ_CLR: begin
          if (st.wstrb[0]) begin
            next_st.irq_stat = st.irq_stat & ~st.wdata[2:0];
          end
        end
        `DADC_OFS_STAT, `DADC_OFS_IRQ_STAT, `DADC_OFS_RES_A, `DADC_OFS_RES_B: begin
          next_st.bresp = 2'h0;
        end
        default: begin
          next_st.bresp = 2'h2;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | ev;
    // Read channel: one read in flight
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'h0;
      unique case ({i_araddr[5:2], 2'h0})
        `DADC_OFS_CTRL: next_st.rdata = 32'(st.ctrl);
        `DADC_OFS_STAT: next_st.rdata = {21'h0, pwr_b, pwr_a, st.range_flag, twos, o_stabilizer_on};
        `DADC_OFS_IRQ_STAT: next_st.rdata = 32'(st.irq_stat);
        `DADC_OFS_IRQ_EN: next_st.rdata = 32'(st.irq_en);
        `DADC_OFS_IRQ_CLR: next_st.rdata = 32'h0000_0000;
        `DADC_OFS_RES_A: next_st.rdata = 32'(st.res_a);
        `DADC_OFS_RES_B: next_st.rdata = 32'(st.res_b);
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'h2;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.oe_n_a <= 1'b1;
      st.oe_n_b <= 1'b1;
      st.ctrl <= 7'(`DADC_CTRL_RST);
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Stabilizer on only at the two middle levels
  assign o_stabilizer_on = (mode_sel == DADC_SEL_THIRD) || (mode_sel == DADC_SEL_TWO_THIRDS);
  assign o_power_state_a = pwr_a;
  assign o_power_state_b = pwr_b;
  assign o_result_bus_a = st.bus_a;
  assign o_result_bus_b = st.bus_b;
  assign o_result_bus_a_oe_n = st.oe_n_a;
  assign o_result_bus_b_oe_n = st.oe_n_b;
  assign o_data_ready_clock = st.dr_clk;
  assign o_range_exceeded_flag = st.range_flag;
  assign o_irq = |(st.irq_stat & st.irq_en);
  assign o_awready = !st.aw_got;
  assign o_wready = !st.w_got;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = !st.rvalid;
  assign o_rvalid = st.rvalid;
  assign o_rresp = st.rresp;
  assign o_rdata = st.rdata;

endmodule
`default_nettype wire

/* File: dadc_output_control_asserts.sv */
// Purpose: Port checks for the dual converter output block
// Assumes: One i_clk domain, async active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module dadc_output_control_asserts
  import dadc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sample_clock_chan_b,
  input wire logic [5:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic o_result_bus_a_oe_n,
  input wire logic o_result_bus_b_oe_n,
  input wire logic o_data_ready_clock,
  input wire logic [3:0] o_power_state_a,
  input wire logic [3:0] o_power_state_b
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////
  // Settled over several edges: enables are registered and reset may lift on an edge
  sequence both_drive;
    (o_power_state_a == DADC_RUN_DRIVE && o_power_state_b == DADC_RUN_DRIVE) [*3];
  endsequence
  sequence both_off;
    (o_power_state_a != DADC_RUN_DRIVE && o_power_state_b != DADC_RUN_DRIVE) [*2];
  endsequence
  sequence wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  pwr_onehot_a: assert property ($onehot(o_power_state_a))
    else $error("power state a not one-hot");
  pwr_onehot_b: assert property ($onehot(o_power_state_b))
    else $error("power state b not one-hot");
  bus_drive_a: assert property (both_drive |-> !o_result_bus_a_oe_n && !o_result_bus_b_oe_n)
    else $error("bus not driven in run state");
  bus_hiz_a: assert property (both_off |-> o_result_bus_a_oe_n && o_result_bus_b_oe_n)
    else $error("bus driven while released");
  rdy_rise_a: assert property ($rose(o_data_ready_clock) |-> $past(i_sample_clock_chan_b, 2))
    else $error("ready clock rose without channel b clock");
  rdy_fall_a: assert property ($fell(o_data_ready_clock) |-> !$past(i_sample_clock_chan_b, 2))
    else $error("ready clock fell without channel b clock");
  // Address and data are held one edge, the response rises on the next
  wr_answer_a: assert property (wr_taken ##0 !o_bvalid |-> ##2 o_bvalid)
    else $error("write response late");
  bad_write_a: assert property (wr_taken ##0 !o_bvalid ##0 (i_awaddr[5:2] > 4'h6) |-> ##2 o_bresp == 2'h2)
    else $error("unmapped write not refused");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  resp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
endmodule
bind dadc_output_control dadc_output_control_asserts dadc_output_control_asserts_inst (
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_sample_clock_chan_b(i_sample_clock_chan_b),
  .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid),
  .o_awready(o_awready),
  .i_wvalid(i_wvalid),
  .o_wready(o_wready),
  .o_bresp(o_bresp),
  .o_bvalid(o_bvalid),
  .i_bready(i_bready),
  .i_arvalid(i_arvalid),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .o_result_bus_a_oe_n(o_result_bus_a_oe_n),
  .o_result_bus_b_oe_n(o_result_bus_b_oe_n),
  .o_data_ready_clock(o_data_ready_clock),
  .o_power_state_a(o_power_state_a),
  .o_power_state_b(o_power_state_b)
);
`default_nettype wire

/* File: dadc_capture_model.sv */
// Purpose: Receiving capture logic beside the result buses
// Assumes: Bus inputs already resolved for high impedance
// Notes: Behavioural, no reset
`timescale 1ns/100ps
`default_nettype none
module dadc_capture_model (
  input wire logic i_data_ready_clock,
  input wire logic [13:0] i_bus_a,
  input wire logic [13:0] i_bus_b,
  output logic [13:0] o_cap_a,
  output logic [13:0] o_cap_b
);
  ////////////////////////////////////////
  // Falling edge only, data is mid-eye there
  always @(negedge i_data_ready_clock) begin
    o_cap_a <= i_bus_a;
    o_cap_b <= i_bus_b;
  end
endmodule
`default_nettype wire

/* File: dual_adc_output_control_tb_top.sv */
// Purpose: Self-checking bench of the converter output block
// Assumes: Shared 125 ns sample clock for both channels
// Notes: Released bus is seen inverted by the capture side
`timescale 1ns/100ps
`default_nettype none
module dual_adc_output_control_tb_top;
  logic i_clk, i_resetn, sclk, rng_a, rng_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, oen_a, oen_b, drc, flag, stab, irq;
  logic [13:0] raw_a, raw_b, cap_a, cap_b, bus_a, bus_b;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] pwr_a, pwr_b;
  int n_mismatch = 0;
  int tests_run = 0;
  wire logic [13:0] wa = oen_a ? ~bus_a : bus_a;
  wire logic [13:0] wb = oen_b ? ~bus_b : bus_b;
  dadc_output_control dadc_output_control_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_sample_clock_chan_a(sclk), .i_sample_clock_chan_b(sclk),
    .i_raw_a(raw_a), .i_raw_b(raw_b), .i_range_a(rng_a), .i_range_b(rng_b),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_result_bus_a(bus_a), .o_result_bus_b(bus_b),
    .o_result_bus_a_oe_n(oen_a), .o_result_bus_b_oe_n(oen_b), .o_data_ready_clock(drc),
    .o_range_exceeded_flag(flag), .o_stabilizer_on(stab), .o_power_state_a(pwr_a),
    .o_power_state_b(pwr_b), .o_irq(irq));
  dadc_capture_model dadc_capture_model_inst (.i_data_ready_clock(drc), .i_bus_a(wa),
    .i_bus_b(wb), .o_cap_a(cap_a), .o_cap_b(cap_b));
  ////////////////////////////////////////
  // Clocks; sample clock phase unrelated to i_clk
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    sclk = 0;
    #1.3;
    forever #62.5 sclk = ~sclk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AXI4-Lite transfer; checks sampled at negedge, acted on at posedge
  task axi(input logic wr, input logic [5:0] a, input logic [31:0] d);
    logic oa, ow, ob, oar, orr, done;
    done = 0;
    if (wr) begin
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    end else begin
      araddr <= a; arvalid <= 1; rready <= 1;
    end
    // No cycle limit here; only the watchdog ends a wait
    while (!done) begin
      @(negedge i_clk);
      oa = awvalid && awready; ow = wvalid && wready; oar = arvalid && arready;
      ob = bready && bvalid; orr = rready && rvalid;
      rsp = ob ? bresp : rresp;
      rd = rdata;
      @(posedge i_clk);
      if (oa) awvalid <= 0;
      if (ow) wvalid <= 0;
      if (oar) arvalid <= 0;
      if (ob) bready <= 0;
      if (orr) rready <= 0;
      done = ob || orr;
    end
    // One idle edge so the next call never re-drives a signal in this step
    @(posedge i_clk);
    chk("bus resp", (a[5:2] > 4'h6) ? 32'h2 : 32'h0, rsp);
  endtask
  task ws(input int n);
    repeat (n) @(posedge sclk);
    repeat (10) @(posedge i_clk);
  endtask
  ////////////////////////////////////////
  task t_format;
    int m;
    logic [13:0] ea, eb;
    for (m = 0; m < 4; m++) begin
      axi(1, 6'h00, {29'h0, m[1:0], 1'b1});
      ws(7);
      ea = (m >= 2) ? raw_a ^ 14'h2000 : raw_a;
      eb = (m >= 2) ? raw_b ^ 14'h2000 : raw_b;
      chk("bus a", ea, bus_a);
      chk("bus b", eb, bus_b);
      chk("capture a", ea, cap_a);
      chk("capture b", eb, cap_b);
      chk("stabilizer", m == 1 || m == 2, stab);
    end
    $display("format test done");
  endtask
  task t_swap;
    axi(1, 6'h00, 32'h0);
    axi(1, 6'h0C, 32'h1);
    ws(7);
    chk("swap a", raw_b, bus_a);
    chk("swap b", raw_a, bus_b);
    chk("flag idle", 0, flag);
    chk("irq idle", 0, irq);
    rng_a <= 1;
    ws(7);
    chk("flag set", 1, flag);
    chk("irq set", 1, irq);
    axi(0, 6'h08, 32'h0);
    chk("irq status", 1, rd[0]);
    axi(1, 6'h0C, 32'h0);
    chk("irq masked", 0, irq);
    axi(1, 6'h0C, 32'h1);
    axi(1, 6'h10, 32'h1);
    chk("irq cleared", 0, irq);
    axi(0, 6'h3C, 32'h0);
    chk("bad read", 2'h2, rsp);
    axi(1, 6'h3C, 32'h5);
    chk("bad write", 2'h2, rsp);
    rng_a <= 0;
    ws(7);
    chk("flag clear", 0, flag);
    $display("swap test done");
  endtask
  task t_power;
    int c;
    int ep;
    // Both channels share one state so the all-released check is reached too
    for (c = 0; c < 4; c++) begin
      axi(1, 6'h00, {25'h0, c[1], c[1], c[0], c[0], 3'h1});
      repeat (3) @(posedge i_clk);
      ep = c == 0 ? 1 : c == 1 ? 4 : c == 2 ? 2 : 8;
      chk("power a", ep, pwr_a);
      chk("power b", ep, pwr_b);
      chk("release a", c != 0, oen_a);
      chk("release b", c != 0, oen_b);
      axi(0, 6'h00, 32'h0);
      chk("ctrl read", {25'h0, c[1], c[1], c[0], c[0], 3'h1}, rd);
    end
    $display("power test done");
  endtask
  task t_latency;
    axi(1, 6'h00, 32'h1);
    ws(7);
    ws(1);
    raw_a <= 14'h0F0F;
    ws(5);
    chk("latency old", 14'h1234, bus_a);
    ws(1);
    chk("latency new", 14'h0F0F, bus_a);
    $display("latency test done");
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 9 us of tests
  initial begin
    #60000;
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    i_resetn = 0; rng_a = 0; rng_b = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    raw_a = 14'h1234;
    raw_b = 14'h3ACE;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1;
    t_format();
    t_swap();
    t_power();
    t_latency();
    tally_and_finish();
  end
endmodule
`default_nettype wire
